//--- shared/mbn_pkg.sv
// Shared constants and types for the multiplexed block I/O bus node.
// Assumes one 20 MHz clock; bus inputs already synchronous to it.
package mbn_pkg;
    localparam int AD_W     = 16;
    localparam int DEV_W    = 4;
    localparam int ADDR_W   = 24;
    localparam int RXF_DEPTH = 8;
    localparam int MAX_DEVS = 16;
    // Field positions of the first address word
    localparam int W0_SEL   = 0;
    localparam int W0_RNW   = 1;
    localparam int W0_MR    = 2;
    localparam int W0_DEV   = 4;
    localparam int W0_AHI   = 8;
    localparam logic [AD_W-1:0] BYTE_MASK = 16'h00FF;
    localparam logic [AD_W-1:0] WORD_MASK = 16'hFFFF;
    localparam logic            RES_BIT   = 1'h0;

    typedef enum logic [1:0] {
        LVL_BASIC = 2'b00,
        LVL_CTRL  = 2'b01,
        LVL_SUP   = 2'b10
    } mbn_level_t;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_AW0  = 2'b01,
        M_AW1  = 2'b10,
        M_DATA = 2'b11
    } mbn_mst_t;

    // Target of a transfer: select flag, device, space, direction, address
    typedef struct packed {
        logic              sel;
        logic [DEV_W-1:0]  dev;
        logic              mr;
        logic              rnw;
        logic [ADDR_W-1:0] addr;
    } mbn_cmd_t;

    typedef struct packed {
        mbn_mst_t        mst;
        logic            hs;
        logic            slv_word;
        logic [AD_W-1:0] slv_w0;
        logic            slv_ack;
        logic            slv_sel;
        mbn_cmd_t        cur;
        logic [1:0]      tk_ph;
        logic [AD_W-1:0] tk_data;
        logic            ls_ack;
        logic            supervisor_takeover_irq;
        logic            sto_seen;
        logic            srq_seen;
    } mbn_state_t;

    localparam mbn_state_t ST_RST = '0;
endpackage

//--- rtl/mbn_node.sv
// Bus node for the multiplexed block I/O bus: address/data handshakes,
// master, slave, talker and listener roles, parity and interrupt lines.
// Assumes all bus inputs are already synchronous to clk_i.
//
// How it works
// - Node is selected only by its own 4-bit device number, so sixteen can share.
// - Data moves as 16-bit words, or 8-bit in the low byte.
// - Address word carries memory/register select over a 24-bit space.
// - Shared lines carry address while the mode line is high, data else.
// - Every idle non-supervisor node acknowledges every address word the master broadcasts.
// - Mode, direction, ready and accept lines pace each transfer.
// - Takeover and service request lines driven and watched.
// - Optional odd parity line; bus reset line resets the node.
// - A basic node never starts a transfer.
// - Controller answers requests and may master transfers.
// - Supervisor drives active and reset lines and watches interrupts.
// - Node starts no master transfer while selected as a slave; one started in the cycle it is selected overlaps it for one cycle.
// - A supervisor never becomes a slave.
// - Selected node talks on reads, listens on writes.
// - Talker and listener roles never held together.
// - Two address words select or deselect a device and target.
// - Data only moves after a completed selection, until deselection.
// - Talker makes odd parity; listener error raises takeover.
// - Words hold device, space bit, direction bit and 24-bit address.
`timescale 1ns/1ns

module mbn_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wp;
        logic [PW:0]                 rp;
    } mbn_fifo_st_t;

    mbn_fifo_st_t st_r;
    mbn_fifo_st_t st_nxt;
    logic         full;
    logic         empty;

    assign empty       = st_r.wp == st_r.rp;
    assign full        = (st_r.wp[PW] != st_r.rp[PW])
                      && (st_r.wp[PW-1:0] == st_r.rp[PW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = st_r.mem[st_r.rp[PW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (in_valid_i && !full) begin
            st_nxt.mem[st_r.wp[PW-1:0]] = in_data_i;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (out_ready_i && !empty) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // mbn_fifo

module mbn_node
    import mbn_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Node configuration
    input  wire mbn_level_t       level_i,
    input  wire logic [DEV_W-1:0] dev_id_i,
    input  wire logic             par_en_i,
    input  wire logic             byte_mode_i,
    // Master command port
    input  wire logic             cmd_valid_i,
    output logic                  cmd_ready_o,
    input  wire mbn_cmd_t         cmd_i,
    // Outgoing data when talking
    input  wire logic             tx_valid_i,
    output logic                  tx_ready_o,
    input  wire logic [AD_W-1:0]  tx_data_i,
    // Incoming data when listening
    output logic                  rx_valid_o,
    input  wire logic             rx_ready_i,
    output logic      [AD_W-1:0]  rx_data_o,
    // Status
    output mbn_cmd_t              cur_o,
    output logic                  selected_o,
    output logic                  talk_o,
    output logic                  listen_o,
    output logic                  sto_seen_o,
    output logic                  srq_seen_o,
    input  wire logic             sto_req_i,
    input  wire logic             sto_clr_i,
    input  wire logic             srq_req_i,
    input  wire logic             bus_rst_req_i,
    // Bus lines, logical level, high = asserted
    input  wire logic [AD_W-1:0]  ad_i,
    output logic      [AD_W-1:0]  ad_o,
    output logic                  ad_oe_o,
    input  wire logic             adm_i,
    output logic                  adm_o,
    output logic                  adm_oe_o,
    input  wire logic             rnw_i,
    output logic                  rnw_o,
    output logic                  rnw_oe_o,
    input  wire logic             drdy_i,
    output logic                  drdy_o,
    output logic                  drdy_oe_o,
    input  wire logic             pb_i,
    output logic                  pb_o,
    output logic                  pb_oe_o,
    // Open-drain lines: enable pulls the line to its asserted state
    input  wire logic             dacc_i,
    output logic                  dacc_o,
    output logic                  dacc_oe_o,
    input  wire logic             aacc_i,
    output logic                  aacc_o,
    output logic                  aacc_oe_o,
    input  wire logic             supervisor_takeover_irq_i,
    output logic                  supervisor_takeover_irq_o,
    output logic                  supervisor_takeover_irq_oe_o,
    input  wire logic             service_request_irq_i,
    output logic                  service_request_irq_o,
    output logic                  service_request_irq_oe_o,
    input  wire logic             sa_i,
    output logic                  sa_o,
    output logic                  sa_oe_o,
    input  wire logic             bus_rst_i,
    output logic                  bus_rst_o,
    output logic                  bus_rst_oe_o
);
    mbn_state_t      st_r;
    mbn_state_t      st_nxt;
    logic            rst;
    logic            in_aw;
    logic            act;
    logic            talk;
    logic            listen;
    logic            push;
    logic            fifo_rdy;
    logic [AD_W-1:0] w0;
    logic [AD_W-1:0] w1;

    assign rst = srst_i || bus_rst_i;

    assign in_aw  = (st_r.mst == M_AW0) || (st_r.mst == M_AW1);
    assign act    = (st_r.mst == M_DATA) || st_r.slv_sel;
    assign talk   = act && !adm_i && ((st_r.mst == M_DATA)
                  ? !st_r.cur.rnw : st_r.cur.rnw);
    assign listen = act && !adm_i && !talk;
    assign push   = listen && drdy_i && !st_r.ls_ack && fifo_rdy;

    assign w0 = {st_r.cur.addr[23:16], st_r.cur.dev, RES_BIT,
                 st_r.cur.mr, st_r.cur.rnw, st_r.cur.sel};
    assign w1 = st_r.cur.addr[15:0];

    assign cmd_ready_o = (level_i != LVL_BASIC) && !st_r.slv_sel
                      && ((st_r.mst == M_IDLE)
                      || (st_r.mst == M_DATA && st_r.tk_ph == 2'd0
                      && !st_r.ls_ack));
    assign tx_ready_o  = talk && st_r.tk_ph == 2'd0;

    // Bus drivers
    assign ad_o      = (st_r.mst == M_AW0) ? w0 : (in_aw ? w1 : st_r.tk_data);
    assign ad_oe_o   = in_aw || (talk && st_r.tk_ph != 2'd0);
    assign adm_o     = in_aw;
    assign adm_oe_o  = st_r.mst != M_IDLE;
    assign rnw_o     = st_r.cur.rnw;
    assign rnw_oe_o  = adm_oe_o;
    assign drdy_o    = 1'b1;
    assign drdy_oe_o = (in_aw && !st_r.hs)
                    || (talk && st_r.tk_ph == 2'd1);
    assign pb_o      = ~^ad_o;
    assign pb_oe_o   = ad_oe_o && par_en_i;
    assign dacc_o    = 1'b1;
    assign dacc_oe_o = st_r.ls_ack;
    assign aacc_o    = 1'b1;
    assign aacc_oe_o = st_r.slv_ack;
    assign supervisor_takeover_irq_o    = 1'b1;
    assign supervisor_takeover_irq_oe_o = st_r.supervisor_takeover_irq || sto_req_i;
    assign service_request_irq_o        = 1'b1;
    assign service_request_irq_oe_o     = srq_req_i;
    assign sa_o         = 1'b1;
    assign sa_oe_o      = level_i == LVL_SUP;
    assign bus_rst_o    = 1'b1;
    assign bus_rst_oe_o = (level_i == LVL_SUP) && bus_rst_req_i;

    assign cur_o      = st_r.cur;
    assign selected_o = st_r.slv_sel;
    assign talk_o     = talk;
    assign listen_o   = listen;
    assign sto_seen_o = st_r.sto_seen;
    assign srq_seen_o = st_r.srq_seen;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sto_seen = (level_i == LVL_SUP) && supervisor_takeover_irq_i;
        st_nxt.srq_seen = (level_i == LVL_SUP) && service_request_irq_i;

        // Master side: two address words, then data until deselected
        case (st_r.mst)
            M_IDLE, M_DATA: begin
                if (cmd_valid_i && cmd_ready_o) begin
                    st_nxt.cur = cmd_i;
                    st_nxt.mst = M_AW0;
                    st_nxt.hs  = 1'b0;
                end
            end
            M_AW0, M_AW1: begin
                if (!st_r.hs && aacc_i) begin
                    st_nxt.hs = 1'b1;
                end else if (st_r.hs && !aacc_i) begin
                    st_nxt.hs = 1'b0;
                    if (st_r.mst == M_AW0) begin
                        st_nxt.mst = M_AW1;
                    end else begin
                        st_nxt.mst = st_r.cur.sel ? M_DATA : M_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.mst = M_IDLE;
            end
        endcase

        // Slave side: watch every address pair, match own number
        if (!adm_i) begin
            st_nxt.slv_word = 1'b0;
        end
        if (st_r.mst == M_IDLE && level_i != LVL_SUP) begin
            if (adm_i && drdy_i && !st_r.slv_ack) begin
                st_nxt.slv_ack = 1'b1;
                if (!st_r.slv_word) begin
                    st_nxt.slv_word = 1'b1;
                    st_nxt.slv_w0   = ad_i;
                end else begin
                    st_nxt.slv_word = 1'b0;
                    if (st_r.slv_w0[W0_DEV +: DEV_W] == dev_id_i) begin
                        st_nxt.slv_sel  = st_r.slv_w0[W0_SEL];
                        st_nxt.cur.sel  = st_r.slv_w0[W0_SEL];
                        st_nxt.cur.dev  = st_r.slv_w0[W0_DEV +: DEV_W];
                        st_nxt.cur.mr   = st_r.slv_w0[W0_MR];
                        st_nxt.cur.rnw  = st_r.slv_w0[W0_RNW];
                        st_nxt.cur.addr = {st_r.slv_w0[W0_AHI +: 8], ad_i};
                    end
                end
            end else if (st_r.slv_ack && !drdy_i) begin
                st_nxt.slv_ack = 1'b0;
            end
        end else begin
            st_nxt.slv_ack = 1'b0;
            st_nxt.slv_sel = 1'b0;
        end

        // Talker: hold data and ready until accepted and released
        if (!talk) begin
            st_nxt.tk_ph = 2'd0;
        end else begin
            case (st_r.tk_ph)
                2'd0: begin
                    if (tx_valid_i) begin
                        st_nxt.tk_data = tx_data_i
                            & (byte_mode_i ? BYTE_MASK : WORD_MASK);
                        st_nxt.tk_ph = 2'd1;
                    end
                end
                2'd1: begin
                    if (dacc_i) begin
                        st_nxt.tk_ph = 2'd2;
                    end
                end
                2'd2: begin
                    if (!dacc_i) begin
                        st_nxt.tk_ph    = 2'd0;
                        st_nxt.cur.addr = st_r.cur.addr + 1'b1;
                    end
                end
                default: begin
                    st_nxt.tk_ph = 2'd0;
                end
            endcase
        end

        // Listener: accept into the FIFO, release when ready drops
        if (!listen) begin
            st_nxt.ls_ack = 1'b0;
        end else if (push) begin
            st_nxt.ls_ack   = 1'b1;
            st_nxt.cur.addr = st_r.cur.addr + 1'b1;
        end else if (st_r.ls_ack && !drdy_i) begin
            st_nxt.ls_ack = 1'b0;
        end

        // Takeover flag: a new error wins over a clear in the same cycle
        if (sto_clr_i) begin
            st_nxt.supervisor_takeover_irq = 1'b0;
        end
        if (push && par_en_i && !(^{ad_i, pb_i})) begin
            st_nxt.supervisor_takeover_irq = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    mbn_fifo #(
        .WIDTH (AD_W),
        .DEPTH (RXF_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .srst_i      (rst),
        .in_valid_i  (push),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (ad_i),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst);

    chk_basic_no_master: assert property (
        level_i == LVL_BASIC |-> !adm_oe_o && !cmd_ready_o)
        else $error("basic node drives the mode line");
    chk_sup_no_slave: assert property (
        level_i == LVL_SUP |-> !st_r.slv_sel && !aacc_oe_o)
        else $error("supervisor acts as slave");
    chk_one_role: assert property (
        !(talk && listen) && !(dacc_oe_o && st_r.tk_ph != 2'd0))
        else $error("talker and listener at once");
    chk_idle_quiet: assert property (
        !act && st_r.mst == M_IDLE |-> !ad_oe_o && !dacc_oe_o)
        else $error("unselected node drives data");
    chk_parity_odd: assert property (
        pb_oe_o |-> ^{ad_o, pb_o})
        else $error("driven parity is not odd");
    chk_parity_err: assert property (
        push && par_en_i && !(^{ad_i, pb_i}) |=> supervisor_takeover_irq_oe_o)
        else $error("parity error did not raise takeover");
    chk_ready_hold: assert property (
        drdy_oe_o && talk && !dacc_i |=> drdy_oe_o || !talk)
        else $error("talker dropped ready before accept");
    chk_acc_hold: assert property (
        dacc_oe_o && drdy_i && listen |=> dacc_oe_o)
        else $error("listener dropped accept early");
    chk_mst_excl: assert property (
        adm_oe_o |-> !st_r.slv_sel)
        else $error("master while selected as slave");
    chk_sel_after_addr: assert property (
        $rose(st_r.slv_sel) |-> $past(adm_i) && $past(drdy_i))
        else $error("selection without address word");
endmodule // mbn_node

//--- testbench/mbn_peer.sv
// Far-side bus peer: master, addressed slave or listener, and the
// resolution of every shared and open-drain line of the bus.
// Assumes one caller per role at a time, all on the bench clock.
`timescale 1ns/1ns
module mbn_peer (
    input  wire logic        clk_i,
    input  wire logic [15:0] dut_ad_i,
    input  wire logic        dut_ad_oe_i,
    input  wire logic [3:0]  dut_ctl_i,
    input  wire logic [5:0]  dut_od_i,
    output logic      [15:0] ad_o,
    output logic      [3:0]  ctl_o,
    output logic      [5:0]  od_o
);
    // ctl: adm, rnw, drdy, pb; od: dacc, aacc, sto, srq, sa, rst
    logic [15:0] p_ad = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] s_ad;
    logic [3:0]  p_ctl = 4'h0;
    logic [5:0]  p_od = 6'h00;
    logic        p_oe = 1'b0;
    logic        s_pb;
    // Released data lines float: they show the inverse of the last value
    assign ad_o = dut_ad_oe_i ? dut_ad_i : (p_oe ? p_ad : ~last);
    assign ctl_o = dut_ctl_i | p_ctl;
    assign od_o = dut_od_i | p_od;
    always @(posedge clk_i) begin
        if (dut_ad_oe_i || p_oe) last <= ad_o;
    end
    // Bounded wait for a line level; index 6 is the ready line
    task automatic wait_line(input int idx, input logic lvl,
                             output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge clk_i);
            ok = ((idx == 6) ? ctl_o[1] : od_o[idx]) === lvl;
            s_ad = ad_o;
            s_pb = ctl_o[0];
        end
        @(posedge clk_i);
    endtask
    // Master sends one word four-phase, odd parity unless told to break it
    task automatic mst_word(input logic adm, input logic [15:0] w,
                            input logic bad, output logic ok);
        logic ok2;
        @(posedge clk_i);
        p_ad <= w;
        p_oe <= 1'b1;
        p_ctl <= {adm, 1'b0, 1'b1, ~^w ^ bad};
        wait_line(adm ? 4 : 5, 1'b1, ok);
        p_ctl[1] <= 1'b0;
        p_oe <= 1'b0;
        wait_line(adm ? 4 : 5, 1'b0, ok2);
        ok = ok & ok2;
    endtask
    // Listener or addressed slave: takes one word, accepts after dly cycles
    task automatic lsn_word(input logic mst, input int ack, input int dly,
                            output logic [15:0] w, output logic pb,
                            output logic ok);
        logic ok2;
        @(posedge clk_i);
        if (mst) p_ctl <= 4'b0100;
        wait_line(6, 1'b1, ok);
        w = s_ad;
        pb = s_pb;
        repeat (dly) @(posedge clk_i);
        p_od[ack] <= 1'b1;
        wait_line(6, 1'b0, ok2);
        p_od[ack] <= 1'b0;
        ok = ok & ok2;
    endtask
    task automatic idle();
        @(posedge clk_i);
        p_ctl <= 4'h0;
    endtask
endmodule // mbn_peer

//--- testbench/mbn_node_tb.sv
// Self-checking bench: bus node against the behavioural bus peer.
// Assumes mbn_peer on the far side and a 20 MHz clock.
`timescale 1ns/1ns
module mbn_node_tb;
    import mbn_pkg::*;
    logic clk_i = 1'b0, srst_i = 1'b1, par_en_i = 1'b1, byte_mode_i = 1'b0;
    logic cmd_valid_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0;
    logic sto_req_i = 1'b0, sto_clr_i = 1'b0, srq_req_i = 1'b0;
    logic bus_rst_req_i = 1'b0, pb, ok;
    mbn_level_t level_i = LVL_BASIC;
    logic [DEV_W-1:0] dev_id_i = 4'h5;
    mbn_cmd_t cmd_i = '0, cur_o, c;
    logic [AD_W-1:0] tx_data_i = 16'h0000, rx_data_o, ad_o, ad, w;
    logic cmd_ready_o, tx_ready_o, rx_valid_o, selected_o, talk_o, listen_o;
    logic sto_seen_o, srq_seen_o, ad_oe_o, adm_o, adm_oe_o, rnw_o, rnw_oe_o;
    logic drdy_o, drdy_oe_o, pb_o, pb_oe_o, dacc_oe_o, aacc_oe_o, sa_oe_o;
    logic supervisor_takeover_irq_oe_o, service_request_irq_oe_o, bus_rst_oe_o;
    logic [3:0] ctl;
    logic [5:0] od;
    logic [23:0] a;
    logic [AD_W-1:0] exp_q[$], wv[4];
    int num_errors = 0, total_checks = 0;
    mbn_node i_dut (.clk_i, .srst_i, .level_i, .dev_id_i, .par_en_i,
        .byte_mode_i, .cmd_valid_i, .cmd_ready_o, .cmd_i, .tx_valid_i,
        .tx_ready_o, .tx_data_i, .rx_valid_o, .rx_ready_i, .rx_data_o, .cur_o,
        .selected_o, .talk_o, .listen_o, .sto_seen_o, .srq_seen_o, .sto_req_i,
        .sto_clr_i, .srq_req_i, .bus_rst_req_i, .ad_i(ad), .ad_o, .ad_oe_o,
        .adm_i(ctl[3]), .adm_o, .adm_oe_o, .rnw_i(ctl[2]), .rnw_o, .rnw_oe_o,
        .drdy_i(ctl[1]), .drdy_o, .drdy_oe_o, .pb_i(ctl[0]), .pb_o, .pb_oe_o,
        .dacc_i(od[5]), .dacc_o(), .dacc_oe_o, .aacc_i(od[4]), .aacc_o(),
        .aacc_oe_o, .supervisor_takeover_irq_i(od[3]),
        .supervisor_takeover_irq_o(), .supervisor_takeover_irq_oe_o,
        .service_request_irq_i(od[2]), .service_request_irq_o(),
        .service_request_irq_oe_o, .sa_i(od[1]), .sa_o(), .sa_oe_o,
        .bus_rst_i(od[0]), .bus_rst_o(), .bus_rst_oe_o);
    mbn_peer i_peer (.clk_i, .dut_ad_i(ad_o), .dut_ad_oe_i(ad_oe_o),
        .dut_ctl_i({adm_o & adm_oe_o, rnw_o & rnw_oe_o, drdy_o & drdy_oe_o,
                    pb_o & pb_oe_o}),
        .dut_od_i({dacc_oe_o, aacc_oe_o, supervisor_takeover_irq_oe_o,
                   service_request_irq_oe_o, sa_oe_o, bus_rst_oe_o}),
        .ad_o(ad), .ctl_o(ctl), .od_o(od));
    always #25 clk_i = ~clk_i;
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [AD_W-1:0] got, input logic [AD_W-1:0] e);
        total_checks++;
        if (got !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, e);
        end
    endtask
    task automatic chk_b(input logic got, input logic e);
        chk_w({15'h0000, got}, {15'h0000, e});
    endtask
    task automatic need(input logic r);
        if (r !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask
    function automatic logic [AD_W-1:0] word0(input mbn_cmd_t k);
        return {k.addr[23:16], k.dev, RES_BIT, k.mr, k.rnw, k.sel};
    endfunction
    task automatic do_reset(input mbn_level_t lvl);
        level_i <= lvl;
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Command or talker word handed over on a valid/ready handshake
    task automatic push(input logic is_cmd, input mbn_cmd_t k,
                        input logic [AD_W-1:0] d);
        logic r;
        r = 1'b0;
        @(posedge clk_i);
        if (is_cmd) cmd_valid_i <= 1'b1;
        else tx_valid_i <= 1'b1;
        cmd_i <= k;
        tx_data_i <= d;
        for (int n = 0; n < 60 && !r; n++) begin
            @(negedge clk_i);
            r = (is_cmd ? cmd_ready_o : tx_ready_o) === 1'b1;
        end
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        tx_valid_i <= 1'b0;
        need(r);
    endtask
    task automatic drain(input int cnt);
        int got;
        got = 0;
        @(posedge clk_i);
        rx_ready_i <= 1'b1;
        for (int n = 0; n < 300 && got < cnt; n++) begin
            @(negedge clk_i);
            if (rx_valid_o === 1'b1) begin
                chk_w(rx_data_o, exp_q.pop_front());
                got++;
            end
        end
        @(posedge clk_i);
        rx_ready_i <= 1'b0;
        need(got == cnt);
    endtask
    task automatic peer_addr(input mbn_cmd_t k);
        i_peer.mst_word(1'b1, word0(k), 1'b0, ok);
        chk_b(ok, 1'b1);
        i_peer.mst_word(1'b1, k.addr[15:0], 1'b0, ok);
        chk_b(ok, 1'b1);
    endtask
    task automatic mst_sel(input mbn_cmd_t k);
        fork
            push(1'b1, k, 16'h0000);
            for (int i = 0; i < 2; i++) begin
                i_peer.lsn_word(1'b0, 4, i, w, pb, ok);
                chk_w(w, (i == 0) ? word0(k) : k.addr[15:0]);
            end
        join
    endtask
    // Node talks four words; the peer accepts each ever more slowly
    task automatic talk_run(input logic mst, input logic [AD_W-1:0] m);
        for (int i = 0; i < 4; i++) wv[i] = 16'($urandom);
        fork
            for (int i = 0; i < 4; i++) push(1'b0, cmd_i, wv[i]);
            for (int i = 0; i < 4; i++) begin
                i_peer.lsn_word(mst, 5, i, w, pb, ok);
                chk_w(w, wv[i] & m);
                chk_b(pb, ~^w);
                chk_b(ok, 1'b1);
            end
        join
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(52409));
        do_reset(LVL_BASIC);
        cmd_i <= {1'b1, 4'h9, 1'b0, 1'b0, 24'h000000};
        cmd_valid_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk_b(cmd_ready_o | adm_oe_o, 1'b0);
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        c = {1'b1, 4'h6, 1'b0, 1'b0, 24'h123456};
        peer_addr(c);
        i_peer.mst_word(1'b0, 16'hA5A5, 1'b0, ok);
        chk_b(ok | selected_o, 1'b0);
        c = {1'b1, 4'h5, 1'b1, 1'b0, 24'($urandom)};
        peer_addr(c);
        i_peer.idle();
        @(negedge clk_i);
        chk_b(selected_o, 1'b1);
        chk_b(listen_o & ~talk_o, 1'b1);
        for (int i = 0; i < 8; i++) begin
            w = 16'($urandom);
            exp_q.push_back(w);
            i_peer.mst_word(1'b0, w, i == 2, ok);
            chk_b(ok, 1'b1);
        end
        chk_b(supervisor_takeover_irq_oe_o, 1'b1);
        @(posedge clk_i);
        sto_clr_i <= 1'b1;
        @(posedge clk_i);
        sto_clr_i <= 1'b0;
        @(negedge clk_i);
        chk_b(supervisor_takeover_irq_oe_o, 1'b0);
        w = 16'($urandom);
        exp_q.push_back(w);
        fork
            i_peer.mst_word(1'b0, w, 1'b0, ok);
            begin
                repeat (8) @(negedge clk_i);
                chk_b(dacc_oe_o, 1'b0);
                drain(9);
            end
        join
        @(negedge clk_i);
        chk_b(ok & ~rx_valid_o, 1'b1);
        c.sel = 1'b0;
        peer_addr(c);
        i_peer.idle();
        @(negedge clk_i);
        chk_b(selected_o, 1'b0);
        $display("test basic slave write done");
        do_reset(LVL_CTRL);
        byte_mode_i <= 1'b1;
        c = {1'b1, 4'h5, 1'b0, 1'b1, 24'h00FFFE};
        peer_addr(c);
        i_peer.idle();
        @(negedge clk_i);
        chk_b(talk_o & ~listen_o, 1'b1);
        chk_b(cmd_ready_o, 1'b0);
        talk_run(1'b1, BYTE_MASK);
        repeat (2) @(negedge clk_i);
        a = c.addr + 24'h000004;
        chk_w(cur_o.addr[15:0], a[15:0]);
        chk_w({8'h00, cur_o.addr[23:16]}, {8'h00, a[23:16]});
        byte_mode_i <= 1'b0;
        c.sel = 1'b0;
        peer_addr(c);
        i_peer.idle();
        $display("test slave read done");
        c = {1'b1, 4'h9, 1'b1, 1'b0, 24'($urandom)};
        mst_sel(c);
        talk_run(1'b0, WORD_MASK);
        c.sel = 1'b0;
        mst_sel(c);
        c = {1'b1, 4'h3, 1'b0, 1'b1, 24'($urandom)};
        mst_sel(c);
        w = 16'($urandom);
        exp_q.push_back(w);
        i_peer.mst_word(1'b0, w, 1'b0, ok);
        chk_b(ok & listen_o & ~talk_o, 1'b1);
        drain(1);
        c.sel = 1'b0;
        mst_sel(c);
        repeat (2) @(negedge clk_i);
        chk_b(ad_oe_o | adm_oe_o | drdy_oe_o, 1'b0);
        $display("test master write done");
        do_reset(LVL_SUP);
        srq_req_i <= 1'b1;
        sto_req_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk_b(sa_oe_o & cmd_ready_o, 1'b1);
        chk_b(service_request_irq_oe_o & srq_seen_o, 1'b1);
        chk_b(supervisor_takeover_irq_oe_o & sto_seen_o, 1'b1);
        c = {1'b1, 4'h5, 1'b0, 1'b0, 24'h000010};
        i_peer.mst_word(1'b1, word0(c), 1'b0, ok);
        chk_b(ok | selected_o, 1'b0);
        @(posedge clk_i);
        bus_rst_req_i <= 1'b1;
        @(negedge clk_i);
        chk_b(bus_rst_oe_o, 1'b1);
        @(posedge clk_i);
        bus_rst_req_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk_b(bus_rst_oe_o, 1'b0);
        $display("test supervisor done");
        stop_test();
    end
endmodule // mbn_node_tb
